/* File: verif/host_model.sv */
// Host controller model driving the status register port
// Assumes one bench process calls wr and rd, never both at once
`timescale 1ns/1ps
`default_nettype none

module host_model (
  input  wire logic       clock,
  input  wire logic [7:0] rd_data,
  output var  logic [7:0] addr,
  output var  logic [7:0] wr_data,
  output var  logic       wr_en,
  output var  logic       rd_en
);
  // ------------------------------------------------------------
  // Bus cycles
  // ------------------------------------------------------------
  initial begin
    addr    = 8'h00;
    wr_data = 8'h00;
    wr_en   = 1'b0;
    rd_en   = 1'b0;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    addr    <= a;
    wr_data <= d;
    wr_en   <= 1'b1;
    @(posedge clock);
    wr_en   <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clock);
    rd_en <= 1'b0;
    #1 d = rd_data;
  endtask

  // Current result is only trusted with a direction flag set
  function automatic logic current_ok(input logic [7:0] s2);
    return s2[3] | s2[2];
  endfunction
endmodule // host_model
`default_nettype wire

/* File: verif/pack_status_flag_logic_test.sv */
// Self-checking bench for the pack status flag logic
// Assumes the host model file and design files are compiled first
`timescale 1ns/1ps
`default_nettype none

module pack_status_flag_logic_test
  import pack_status_pkg::*;
;
  logic           clock, rst_b, wr_en, rd_en, recall_done;
  logic [7:0]     addr, wr_data, rd_data, nv_data, cell_below_min, d;
  logic           nv_data_ok, cfg_wr, run_enable;
  logic           wake_req, fet_hold_off, regulator_on;
  nv_read_t       nv_rd;
  current_sense_t dir_in;
  monitor_t       mon;
  power_mode_t    power_mode;
  int             mismatches, n_compared, cycles;

  // Short filter keeps the run brief; tick stays 200 clocks
  pack_status_flag_logic #(.FILTER_TICKS(16'h0004)) uut (
    .clock, .rst_b, .addr, .wr_data, .wr_en, .rd_en, .rd_data,
    .nv_rd, .recall_done, .nv_data, .nv_data_ok, .cfg_wr, .run_enable,
    .dir_in, .mon, .cell_below_min, .power_mode, .wake_req,
    .fet_hold_off, .regulator_on
  );
  host_model host (
    .clock, .rd_data, .addr, .wr_data, .wr_en, .rd_en
  );

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    host.rd(a, d);
    check(d, exp);
  endtask

  task automatic setm(input monitor_t m);
    @(posedge clock) mon <= m;
    repeat (2) @(posedge clock);
    #1;
  endtask

  task automatic nv(input logic r, input logic [7:0] dt, input logic [7:0] f,
                    input logic m);
    logic fail;
    fail = m || $countones(f) > 1;
    @(posedge clock) nv_rd <= {1'b1, r, dt, f, m};
    @(posedge clock) nv_rd <= '0;
    #1 check(nv_data, fail ? dt : dt ^ f);
    check({6'h0, nv_data_ok, cfg_wr}, {6'h0, !fail, r & !fail});
    rd_chk(8'h82, {2'b00, fail, !fail && f != 8'h00, 4'h0});
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic test_ecc();
    // Bad recall word must keep operation off until a reset
    nv(1'b1, 8'h5a, 8'h81, 1'b0);
    @(posedge clock) recall_done <= 1'b1;
    @(posedge clock) recall_done <= 1'b0;
    #1 check({7'h0, run_enable}, 8'h00);
    @(posedge clock) rst_b <= 1'b0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    nv(1'b1, 8'h5a, 8'h10, 1'b0);
    nv(1'b1, 8'h3c, 8'h00, 1'b0);
    @(posedge clock) recall_done <= 1'b1;
    @(posedge clock) recall_done <= 1'b0;
    #1 check({7'h0, run_enable}, 8'h01);
    nv(1'b0, 8'ha5, 8'h01, 1'b0);
    nv(1'b0, 8'ha5, 8'h00, 1'b0);
    nv(1'b0, 8'ha5, 8'h03, 1'b0);
    nv(1'b0, 8'ha5, 8'h00, 1'b1);
    nv(1'b1, 8'h22, 8'h81, 1'b0);
    nv(1'b0, 8'h11, 8'h00, 1'b0);
    $display("test ecc done");
  endtask

  task automatic test_dir();
    @(posedge clock) dir_in <= 2'b10;
    repeat (600) @(posedge clock);
    rd_chk(8'h82, 8'h00);
    repeat (800) @(posedge clock);
    rd_chk(8'h82, 8'h08);
    @(posedge clock) dir_in <= 2'b00;
    repeat (600) @(posedge clock);
    rd_chk(8'h82, 8'h08);
    repeat (800) @(posedge clock);
    rd_chk(8'h82, 8'h00);
    @(posedge clock) dir_in <= 2'b01;
    repeat (600) @(posedge clock);
    rd_chk(8'h82, 8'h00);
    repeat (800) @(posedge clock);
    rd_chk(8'h82, 8'h04);
    check({7'h0, host.current_ok(d)}, 8'h01);
    @(posedge clock) dir_in <= 2'b00;
    repeat (1400) @(posedge clock);
    rd_chk(8'h82, 8'h00);
    $display("test dir done");
  endtask

  task automatic test_attach();
    setm(5'b11100);
    setm(5'b11000);
    rd_chk(8'h82, 8'h02);
    setm(5'b01000);
    rd_chk(8'h82, 8'h00);
    host.wr(8'h87, 8'h08);
    setm(5'b11100);
    setm(5'b01000);
    rd_chk(8'h82, 8'h02);
    rd_chk(8'h82, 8'h00);
    host.wr(8'h87, 8'h10);
    setm(5'b00010);
    setm(5'b01000);
    rd_chk(8'h82, 8'h01);
    rd_chk(8'h82, 8'h00);
    host.wr(8'h87, 8'h00);
    setm(5'b00001);
    setm(5'b00000);
    rd_chk(8'h82, 8'h01);
    setm(5'b01000);
    rd_chk(8'h82, 8'h00);
    rd_chk(8'h87, 8'h00);
    $display("test attach done");
  endtask

  task automatic test_modes();
    power_mode_t pm [3];
    pm = '{PM_IDLE, PM_DOZE, PM_SLEEP};
    for (int i = 0; i < 3; i++) begin
      @(posedge clock) power_mode <= pm[i];
      repeat (2) @(posedge clock);
      rd_chk(8'h83, 8'h10 << i);
    end
    setm(5'b11100);
    check({7'h0, wake_req}, 8'h01);
    setm(5'b01000);
    setm(5'b00010);
    check({7'h0, wake_req}, 8'h01);
    setm(5'b01000);
    @(posedge clock) power_mode <= PM_NORMAL;
    cell_below_min <= 8'hff;
    rd_chk(8'h83, 8'h08);
    host.wr(8'h83, 8'h00);
    host.wr(8'h82, 8'hff);
    rd_chk(8'h83, 8'h08);
    rd_chk(8'h82, 8'h00);
    rd_chk(8'h90, 8'h00);
    @(posedge clock) cell_below_min <= 8'h7f;
    rd_chk(8'h83, 8'h00);
    @(posedge clock) cell_below_min <= 8'hff;
    power_mode <= PM_POWERDOWN;
    setm(5'b00010);
    check({6'h0, regulator_on, fet_hold_off}, 8'h01);
    rd_chk(8'h83, 8'h00);
    @(posedge clock) power_mode <= PM_NORMAL;
    setm(5'b01000);
    check({6'h0, regulator_on, fet_hold_off}, 8'h02);
    $display("test modes done");
  endtask

  // ------------------------------------------------------------
  // Sequence and verdict
  // ------------------------------------------------------------
  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  initial begin
    rst_b          = 1'b0;
    recall_done    = 1'b0;
    nv_rd          = '0;
    dir_in         = '0;
    mon            = 5'b01000;
    cell_below_min = 8'h00;
    power_mode     = PM_NORMAL;
    mismatches     = 0;
    n_compared     = 0;
    cycles         = 0;
    repeat (8) @(posedge clock);
    rst_b <= 1'b1;
    test_ecc();
    test_dir();
    test_attach();
    test_modes();
    stop_test();
  end
endmodule // pack_status_flag_logic_test
`default_nettype wire

/* File: verilog/dir_filter.sv */
// Continuity filter: holds once its level has stayed high for more than LIMIT ticks
// Assumes tick is a one-cycle enable from the timebase divider
`timescale 1ns/1ps
`default_nettype none
`include "pack_status_cfg.svh"

module dir_filter
  import pack_status_pkg::*;
#(
  parameter logic [`FILTER_W-1:0] LIMIT = `FILTER_TICKS
) (
  input  wire logic clock,
  input  wire logic rst_b,
  input  wire logic tick,
  input  wire logic level,
  output var  logic hold
);

  logic [`FILTER_W-1:0] cnt_r;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  // Any drop restarts the count, so only an unbroken run qualifies
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
      hold  <= 1'b0;
    end else if (!level) begin
      cnt_r <= '0;
      hold  <= 1'b0;
    end else if (tick && !hold) begin
      if (cnt_r == LIMIT) begin
        hold <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_hold_late: assert property (
    @(posedge clock) disable iff (!rst_b)
    $rose(hold) |-> (cnt_r == LIMIT) && $past(level))
    else $error("filter held before its full run");

  a_drop_clears: assert property (
    @(posedge clock) disable iff (!rst_b)
    !level |=> !hold && (cnt_r == '0))
    else $error("filter kept state after level dropped");

endmodule // dir_filter

`default_nettype wire

/* File: verilog/pack_status_cfg.svh */
// Offsets, field positions, reset values and timing for the pack status flags
// Assumes inclusion by bare name from the package and the modules
`ifndef PACK_STATUS_CFG_SVH
`define PACK_STATUS_CFG_SVH

// ----------------------------------------------------------------
// Register map
// ----------------------------------------------------------------
`define STAT2_OFS      8'h82
`define STAT3_OFS      8'h83
`define CTRL_OFS       8'h87
`define STAT2_RST      8'h00
`define STAT3_RST      8'h00
`define RD_IDLE        8'h00
`define CTRL_CMON_BIT  3
`define CTRL_LMON_BIT  4

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_NS         5
`define TICK_NS        1000
`define TICK_CYCLES    (`TICK_NS / `CLK_NS)
`define TICK_W         8
`define FILTER_MS      2
`define FILTER_TICKS   16'h07d0
`define FILTER_W       16

`endif

/* File: verilog/pack_status_flag_logic.sv */
// Pack status flags: ECC results, current direction, attach latches, modes
// Assumes inputs synchronous to clock and a one-cycle read/write strobe port
//
// Overview of operation
// - Error-free nonvolatile read clears both ECC flags.
// - Single-bit error corrected, sets corrected flag, fail flag stays 0.
// - Multi-bit error sets fail flag, corrected flag 0, data invalid.
// - Recall corrects single-bit errors; multi-bit errors keep config.
// - Recall must end with clean ECC flags before operation is enabled; only the fail flag is checked, corrected flag may be set.
// - ECC flags self-clear on the next clean read.
// - Outflow flag needs discharge comparator high unbroken for over 2ms.
// - Inflow flag needs sense below negative threshold for over 2ms.
// - Outflow clears after 2ms continuous of charge or no current.
// - Charger flag sets on charge overcurrent while charger connected.
// - No override: charger flag follows charger sense, clears when low.
// - Override: charger flag clears on status two read after sense drop.
// - Charger detection wakes device from powerdown or sleep.
// - Load flag sets on discharge overcurrent or short, load connected.
// - No override: load flag stays while sense low, clears when high.
// - Override: load flag clears on status two read after sense rose.
// - Load detection wakes from sleep; powerdown wake may hold FETs off.
// - Sleep flag set in sleep; cleared by reset, charger rise, load fall.
// - Doze and idle flags follow their modes.
// - All mode flags 0 is normal; powerdown silent, regulator off.
// - Balance undervolt flag set when all cells below minimum, else clear.
//
// Local design decision: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "pack_status_cfg.svh"

module pack_status_flag_logic
  import pack_status_pkg::*;
#(
  parameter logic [`FILTER_W-1:0] FILTER_TICKS = `FILTER_TICKS
) (
  input  wire logic           clock,
  input  wire logic           rst_b,
  input  wire logic [7:0]     addr,
  input  wire logic [7:0]     wr_data,
  input  wire logic           wr_en,
  input  wire logic           rd_en,
  output var  logic [7:0]     rd_data,
  input  wire nv_read_t       nv_rd,
  input  wire logic           recall_done,
  output var  logic [7:0]     nv_data,
  output var  logic           nv_data_ok,
  output var  logic           cfg_wr,
  output var  logic           run_enable,
  input  wire current_sense_t dir_in,
  input  wire monitor_t       mon,
  input  wire logic [7:0]     cell_below_min,
  input  wire power_mode_t    power_mode,
  output var  logic           wake_req,
  output var  logic           fet_hold_off,
  output var  logic           regulator_on
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Returns {fail, used} for one read
  function automatic logic [1:0] ecc_class(input logic [7:0] flip,
                                           input logic       multi);
    logic single;
    single = (flip != 8'h00) && ((flip & 8'(flip - 8'h01)) == 8'h00);
    if (multi || ((flip != 8'h00) && !single)) begin
      ecc_class = 2'b10;
    end else if (single) begin
      ecc_class = 2'b01;
    end else begin
      ecc_class = 2'b00;
    end
  endfunction

  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0]      rd_data_r;
  logic [7:0]      nv_data_r;
  logic            nv_ok_r;
  logic            cfg_wr_r;
  logic            run_r;
  logic            recall_bad_r;
  logic            ecc_used_r;
  logic            ecc_fail_r;
  dir_state_t      dir_r;
  dir_state_t      dir_nxt;
  logic            ch_flag_r;
  logic            ld_flag_r;
  logic            cmon_ovr_r;
  logic            lmon_ovr_r;
  logic            ch_sense_d_r;
  logic            ld_sense_d_r;
  power_mode_t     mode_d_r;
  logic            sleep_r;
  logic            balance_undervolt_flag_r;
  logic            wake_r;
  logic            fet_hold_r;
  logic            reg_on_r;
  logic [`TICK_W-1:0] tick_cnt_r;
  logic            tick_r;
  logic [3:0]      held;
  logic [3:0]      f_level;
  logic [1:0]      cls;
  logic            live;
  logic            st2_rd;
  logic            ch_set;
  logic            ld_set;
  logic            ch_rise;
  logic            ld_fall;
  status_two_t     st2;
  status_three_t   st3;

  assign rd_data      = rd_data_r;
  assign nv_data      = nv_data_r;
  assign nv_data_ok   = nv_ok_r;
  assign cfg_wr       = cfg_wr_r;
  assign run_enable   = run_r;
  assign wake_req     = wake_r;
  assign fet_hold_off = fet_hold_r;
  assign regulator_on = reg_on_r;

  assign cls     = ecc_class(nv_rd.flip, nv_rd.multi);
  assign live    = (power_mode != PM_POWERDOWN);
  assign st2_rd  = rd_en && live && hit(addr, `STAT2_OFS);
  assign ch_set  = mon.charge_overcurrent && mon.charger_sense_input;
  assign ld_set  = (mon.discharge_overcurrent ||
                    mon.discharge_short_circuit) && !mon.load_sense_input;
  assign ch_rise = mon.charger_sense_input && !ch_sense_d_r;
  assign ld_fall = !mon.load_sense_input && ld_sense_d_r;

  // ----------------------------------------------------------------
  // ECC result flags and corrected data
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ecc_used_r <= 1'b0;
      ecc_fail_r <= 1'b0;
      nv_data_r  <= 8'h00;
      nv_ok_r    <= 1'b0;
    end else if (nv_rd.valid) begin
      ecc_used_r <= cls[0];
      ecc_fail_r <= cls[1];
      nv_data_r  <= cls[1] ? nv_rd.data : (nv_rd.data ^ nv_rd.flip);
      nv_ok_r    <= !cls[1];
    end
  end

  // ----------------------------------------------------------------
  // Power-on recall
  // ----------------------------------------------------------------
  // A failed word suppresses the write so the config keeps its old value
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cfg_wr_r     <= 1'b0;
      recall_bad_r <= 1'b0;
      run_r        <= 1'b0;
    end else begin
      cfg_wr_r <= nv_rd.valid && nv_rd.recall && !cls[1];
      if (nv_rd.valid && nv_rd.recall && cls[1]) begin
        recall_bad_r <= 1'b1;
      end
      // Limitation: a bad recall keeps operation off until the next reset
      if (recall_done && !recall_bad_r && !ecc_fail_r) begin
        run_r <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Timebase and direction filters
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b0;
    end else if (tick_cnt_r == `TICK_W'(`TICK_CYCLES - 1)) begin
      tick_cnt_r <= '0;
      tick_r     <= 1'b1;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
      tick_r     <= 1'b0;
    end
  end

  assign f_level = {!dir_in.chg_cmp, !dir_in.dis_cmp,
                    dir_in.chg_cmp, dir_in.dis_cmp};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_filt
      dir_filter #(
        .LIMIT (FILTER_TICKS)
      ) u_filt (
        .clock (clock),
        .rst_b (rst_b),
        .tick  (tick_r),
        .level (f_level[gi]),
        .hold  (held[gi])
      );
    end
  endgenerate

  always_comb begin
    dir_nxt = dir_r;
    case (dir_r)
      DIR_NONE: begin
        if (held[0]) begin
          dir_nxt = DIR_OUT;
        end else if (held[1]) begin
          dir_nxt = DIR_IN;
        end
      end
      DIR_OUT: begin
        if (held[2]) begin
          dir_nxt = held[1] ? DIR_IN : DIR_NONE;
        end
      end
      DIR_IN: begin
        if (held[3]) begin
          dir_nxt = held[0] ? DIR_OUT : DIR_NONE;
        end
      end
      default: dir_nxt = DIR_NONE;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      dir_r <= DIR_NONE;
    end else begin
      dir_r <= dir_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Charger and load attach latches
  // ----------------------------------------------------------------
  // Set wins over clear so a detection in a clearing read is kept
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ch_flag_r <= 1'b0;
    end else if (ch_set) begin
      ch_flag_r <= 1'b1;
    end else if (!mon.charger_sense_input && (!cmon_ovr_r || st2_rd)) begin
      ch_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ld_flag_r <= 1'b0;
    end else if (ld_set) begin
      ld_flag_r <= 1'b1;
    end else if (mon.load_sense_input && (!lmon_ovr_r || st2_rd)) begin
      ld_flag_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Wake requests
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      wake_r     <= 1'b0;
      fet_hold_r <= 1'b0;
    end else begin
      wake_r <= (ch_set && ((power_mode == PM_SLEEP) ||
                            (power_mode == PM_POWERDOWN))) ||
                (ld_set && (power_mode == PM_SLEEP));
      if (ld_set && (power_mode == PM_POWERDOWN)) begin
        fet_hold_r <= 1'b1;
      end else if (!ld_flag_r) begin
        fet_hold_r <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Mode indicators and balance undervoltage
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ch_sense_d_r <= 1'b0;
      ld_sense_d_r <= 1'b1;
      mode_d_r     <= PM_NORMAL;
      sleep_r      <= 1'b0;
      balance_undervolt_flag_r       <= 1'b0;
      reg_on_r     <= 1'b0;
    end else begin
      ch_sense_d_r <= mon.charger_sense_input;
      ld_sense_d_r <= mon.load_sense_input;
      mode_d_r     <= power_mode;
      // Flag arms on sleep entry; wake edges drop it at once
      if (ch_rise || ld_fall || (power_mode != PM_SLEEP)) begin
        sleep_r <= 1'b0;
      end else if (mode_d_r != PM_SLEEP) begin
        sleep_r <= 1'b1;
      end
      balance_undervolt_flag_r   <= &cell_below_min;
      reg_on_r <= live;
    end
  end

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_comb begin
    st2 = status_two_t'(`STAT2_RST);
    st2.ecc_fail               = ecc_fail_r;
    st2.ecc_used               = ecc_used_r;
    st2.outflow_direction_flag = (dir_r == DIR_OUT);
    st2.inflow_direction_flag  = (dir_r == DIR_IN);
    st2.charger_attached_flag  = ch_flag_r;
    st2.load_attached_flag     = ld_flag_r;
    st3 = status_three_t'(`STAT3_RST);
    st3.sleep_state_flag       = sleep_r;
    st3.doze_state_flag        = (power_mode == PM_DOZE);
    st3.idle_state_flag        = (power_mode == PM_IDLE);
    st3.balance_undervolt_flag = balance_undervolt_flag_r;
  end

  // Only the override register accepts writes; status offsets drop them
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      cmon_ovr_r <= 1'b0;
      lmon_ovr_r <= 1'b0;
    end else if (wr_en && live && hit(addr, `CTRL_OFS)) begin
      cmon_ovr_r <= wr_data[`CTRL_CMON_BIT];
      lmon_ovr_r <= wr_data[`CTRL_LMON_BIT];
    end
  end

  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      rd_data_r <= `RD_IDLE;
    end else begin
      rd_data_r <= `RD_IDLE;
      if (rd_en && live) begin
        case (addr)
          `STAT2_OFS: rd_data_r <= st2;
          `STAT3_OFS: rd_data_r <= st3;
          `CTRL_OFS: begin
            rd_data_r[`CTRL_CMON_BIT] <= cmon_ovr_r;
            rd_data_r[`CTRL_LMON_BIT] <= lmon_ovr_r;
          end
          default: rd_data_r <= `RD_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_ecc_clean: assert property (
    @(posedge clock) disable iff (!rst_b)
    nv_rd.valid && !nv_rd.multi && (nv_rd.flip == 8'h00)
    |=> !ecc_used_r && !ecc_fail_r && nv_ok_r)
    else $error("clean read left an ECC flag set");

  a_ecc_single: assert property (
    @(posedge clock) disable iff (!rst_b)
    nv_rd.valid && !nv_rd.multi && $onehot(nv_rd.flip)
    |=> ecc_used_r && !ecc_fail_r
        && (nv_data_r == ($past(nv_rd.data) ^ $past(nv_rd.flip))))
    else $error("single-bit error not corrected");

  a_ecc_multi: assert property (
    @(posedge clock) disable iff (!rst_b)
    nv_rd.valid && (nv_rd.multi || ($countones(nv_rd.flip) > 1))
    |=> ecc_fail_r && !ecc_used_r && !nv_ok_r)
    else $error("multi-bit error not flagged");

  a_recall_keep: assert property (
    @(posedge clock) disable iff (!rst_b)
    nv_rd.valid && nv_rd.recall
    && (nv_rd.multi || ($countones(nv_rd.flip) > 1))
    |=> !cfg_wr_r && recall_bad_r)
    else $error("failed recall word reached config");

  a_run_gate: assert property (
    @(posedge clock) disable iff (!rst_b)
    $rose(run_r) |-> $past(recall_done) && !$past(ecc_fail_r))
    else $error("operation started without a clean recall");

  a_dir_out: assert property (
    @(posedge clock) disable iff (!rst_b)
    (dir_r != DIR_OUT) ##1 (dir_r == DIR_OUT)
    |-> $past(held[0]) && $past(dir_in.dis_cmp))
    else $error("outflow set without full filter run");

  a_dir_leave: assert property (
    @(posedge clock) disable iff (!rst_b)
    (dir_r == DIR_OUT) && dir_in.dis_cmp |=> (dir_r == DIR_OUT))
    else $error("outflow dropped while discharge persists");

  a_ch_auto: assert property (
    @(posedge clock) disable iff (!rst_b)
    !cmon_ovr_r && !mon.charger_sense_input |=> !ch_flag_r)
    else $error("charger flag stayed with sense low");

  a_ch_hold: assert property (
    @(posedge clock) disable iff (!rst_b)
    cmon_ovr_r && ch_flag_r && !st2_rd |=> ch_flag_r)
    else $error("charger flag cleared without a read");

  a_ld_auto: assert property (
    @(posedge clock) disable iff (!rst_b)
    !lmon_ovr_r && mon.load_sense_input |=> !ld_flag_r)
    else $error("load flag stayed with sense high");

  a_ld_hold: assert property (
    @(posedge clock) disable iff (!rst_b)
    lmon_ovr_r && ld_flag_r && !st2_rd |=> ld_flag_r)
    else $error("load flag cleared without a read");

  a_sleep_drop: assert property (
    @(posedge clock) disable iff (!rst_b)
    ch_rise || ld_fall |=> !sleep_r)
    else $error("sleep flag survived a wake edge");

  a_pd_silent: assert property (
    @(posedge clock) disable iff (!rst_b)
    rd_en && (power_mode == PM_POWERDOWN)
    |=> (rd_data_r == `RD_IDLE) && !reg_on_r)
    else $error("powerdown answered a read");

endmodule // pack_status_flag_logic

`default_nettype wire

/* File: verilog/pack_status_pkg.sv */
// Types shared by the pack status flag logic and its filter
// Assumes the cfg header sits beside it on the include path
`include "pack_status_cfg.svh"

package pack_status_pkg;

  typedef enum logic [2:0] {
    PM_NORMAL, PM_IDLE, PM_DOZE, PM_SLEEP, PM_POWERDOWN
  } power_mode_t;

  typedef enum logic [1:0] {DIR_NONE, DIR_OUT, DIR_IN} dir_state_t;

  typedef struct packed {
    logic       valid;
    logic       recall;
    logic [7:0] data;
    logic [7:0] flip;
    logic       multi;
  } nv_read_t;

  typedef struct packed {
    logic dis_cmp;
    logic chg_cmp;
  } current_sense_t;

  typedef struct packed {
    logic charger_sense_input;
    logic load_sense_input;
    logic charge_overcurrent;
    logic discharge_overcurrent;
    logic discharge_short_circuit;
  } monitor_t;

  typedef struct packed {
    logic low_volt_charge;
    logic scan_idle;
    logic ecc_fail;
    logic ecc_used;
    logic outflow_direction_flag;
    logic inflow_direction_flag;
    logic charger_attached_flag;
    logic load_attached_flag;
  } status_two_t;

  typedef struct packed {
    logic rsv;
    logic sleep_state_flag;
    logic doze_state_flag;
    logic idle_state_flag;
    logic balance_undervolt_flag;
    logic cell_over_flag;
    logic cold_flag;
    logic hot_flag;
  } status_three_t;

endpackage
